/* File: design/itb_map.svh */
// Constants for the conditional-block and table-branch decoder
// Overview of operation
// - Prefix makes one to four following instructions conditional
// - First uses base condition, others own letter
// - Then applies base, else applies its inverse
// - Breakpoint inside block always executes
// - Exceptions accepted before or inside the block
// - Exception return resumes remaining block instructions
// - Conditional instructions need block, except immediate branch
// - Prefix leaves condition flags unchanged
// - Byte table reads byte, half table reads halfword
// - Half table index shifted left one bit
// - Counter base means table follows the instruction
// - Target is next address plus twice entry
// - Table branches leave condition flags unchanged
`ifndef ITB_MAP_SVH
`define ITB_MAP_SVH

// ============================================================
// Encodings
`define ITB_COND_ALWAYS   4'hE
`define ITB_MASK_EMPTY    4'h0
`define ITB_MASK_LAST     4'h8
`define ITB_REG_SP        4'hD
`define ITB_REG_PC        4'hF
`define ITB_HALF_SHIFT    1
`define ITB_INSTR_BYTES   32'h0000_0004

`endif

/* File: design/itb_pkg.sv */
// Types for the conditional-block and table-branch decoder
package itb_pkg;

  typedef enum logic [3:0] {
    ITB_K_OTHER  = 4'b0001,
    ITB_K_PREFIX = 4'b0010,
    ITB_K_TBB    = 4'b0100,
    ITB_K_TBH    = 4'b1000
  } itb_kind_t;

  // Decoded instruction offered by fetch
  typedef struct packed {
    logic        valid;
    itb_kind_t   kind;
    logic [3:0]  cond_field;
    logic [3:0]  mask_field;
    logic        is_breakpoint_instr;
    logic        is_cbz;
    logic        is_cps;
    logic        writes_pc;
    logic        is_bcond;
    logic        has_cond;
    logic [3:0]  instr_cond;
    logic [3:0]  base_reg;
    logic [3:0]  index_reg;
    logic [31:0] pc;
  } itb_instr_t;

  // Conditional-block state, also the exception save image
  typedef struct packed {
    logic [3:0] base_cond;
    logic [3:0] mask;
  } itb_blk_t;

  typedef struct packed {
    itb_blk_t    blk;
    logic        tb_busy;
    logic        tb_half;
    logic [31:0] tb_next;
    logic        exec;
    logic        fault;
    logic [31:0] target;
    logic        branch;
    logic [31:0] tb_addr;
    logic        tb_req;
  } itb_state_t;

endpackage

/* File: design/itb_decoder.sv */
// Conditional-block state tracker and table-branch address unit
`timescale 1ns/1ps
`include "itb_map.svh"
module itb_decoder
  import itb_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire itb_instr_t  instr_i,
  input  wire logic [3:0]  flags_i,
  input  wire logic [31:0] base_val_i,
  input  wire logic [31:0] index_val_i,
  input  wire logic        exc_entry_i,
  input  wire logic        exc_return_i,
  input  wire itb_blk_t    exc_restore_i,
  input  wire logic        tbl_valid_i,
  input  wire logic [15:0] tbl_data_i,
  output logic             ready_o,
  output itb_blk_t         blk_state_o,
  output logic             in_block_o,
  output logic             exec_o,
  output logic             fault_o,
  output logic             tbl_req_o,
  output logic [31:0]      tbl_addr_o,
  output logic             tbl_half_o,
  output logic             branch_o,
  output logic [31:0]      target_o
);

  // ============================================================
  // Condition evaluation on N Z C V
  function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cy, v, r;
    n  = f[3];
    z  = f[2];
    cy = f[1];
    v  = f[0];
    unique case (c[3:1])
      3'h0:    r = z;
      3'h1:    r = cy;
      3'h2:    r = n;
      3'h3:    r = v;
      3'h4:    r = cy & ~z;
      3'h5:    r = (n == v);
      3'h6:    r = ~z & (n == v);
      default: r = 1'b1;
    endcase
    if (c[0] && c[3:1] != 3'h7) begin
      r = ~r;
    end
    return r;
  endfunction

  // Condition of the current block slot; its low bit is refilled from the mask
  // on every advance but the last, so the base field always holds the live condition
  function automatic logic [3:0] slot_cond(input itb_blk_t b);
    return b.base_cond;
  endfunction

  itb_state_t st, next_st;
  logic       in_blk;
  logic [3:0] cur_cond;
  logic       last_slot;
  logic [31:0] offs;
  logic       taken;

  assign in_blk    = (st.blk.mask != `ITB_MASK_EMPTY);
  // Instruction accepted this edge with no exception pulse beside it
  assign taken     = ready_o && instr_i.valid && !exc_entry_i && !exc_return_i;
  assign last_slot = (st.blk.mask[2:0] == 3'h0);
  assign cur_cond  = slot_cond(st.blk);
  // Table branch stalls fetch until its entry returns
  assign ready_o   = ~st.tb_busy;

  always_comb begin
    next_st        = st;
    next_st.exec   = 1'b0;
    next_st.fault  = 1'b0;
    next_st.branch = 1'b0;
    next_st.tb_req = 1'b0;
    offs           = 32'h0;
    if (exc_return_i) begin
      next_st.blk     = exc_restore_i;
      next_st.tb_busy = 1'b0;
    end else if (exc_entry_i) begin
      // Block state stays intact for stacking; a pending table read is dropped
      next_st.tb_busy = 1'b0;
    end else if (st.tb_busy) begin
      if (tbl_valid_i) begin
        next_st.tb_busy = 1'b0;
        next_st.branch  = 1'b1;
        next_st.target  = st.tb_next + (st.tb_half ? {15'h0, tbl_data_i, 1'b0}
                                                   : {23'h0, tbl_data_i[7:0], 1'b0});
      end
    end else if (instr_i.valid) begin
      if (in_blk) begin
        // Slot executes on its own condition; breakpoint ignores it
        next_st.exec = cond_pass(cur_cond, flags_i) | instr_i.is_breakpoint_instr;
        next_st.fault = instr_i.kind == ITB_K_PREFIX || instr_i.is_cbz ||
                        instr_i.is_cps || (instr_i.writes_pc && !last_slot) ||
                        (!instr_i.has_cond && !instr_i.is_breakpoint_instr) ||
                        (instr_i.has_cond && instr_i.instr_cond != cur_cond);
        // Shift to next slot; only the top bit left means block over
        next_st.blk.mask = last_slot ? `ITB_MASK_EMPTY : {st.blk.mask[2:0], 1'b0};
        if (last_slot) begin
          next_st.blk.base_cond = 4'h0;
        end else begin
          next_st.blk.base_cond[0] = st.blk.mask[3];
        end
      end else begin
        // Branch outside a block still obeys its own condition
        next_st.exec  = !instr_i.has_cond || cond_pass(instr_i.instr_cond, flags_i);
        next_st.fault = instr_i.has_cond && !instr_i.is_bcond;
      end
      if (next_st.exec && !next_st.fault) begin
        unique case (instr_i.kind)
          ITB_K_PREFIX: begin
            // Flags untouched; only block state loads
            next_st.blk.base_cond = instr_i.cond_field;
            next_st.blk.mask      = instr_i.mask_field;
            // Letter bits sit above the lowest set bit; under the always condition a one there is an else
            if (instr_i.mask_field == `ITB_MASK_EMPTY ||
                (instr_i.cond_field == `ITB_COND_ALWAYS &&
                 (instr_i.mask_field & (instr_i.mask_field - 4'h1)) != 4'h0)) begin
              next_st.fault = 1'b1;
            end
          end
          ITB_K_TBB, ITB_K_TBH: begin
            offs = (instr_i.kind == ITB_K_TBH) ? (index_val_i << `ITB_HALF_SHIFT)
                                               : index_val_i;
            next_st.tb_next = instr_i.pc + `ITB_INSTR_BYTES;
            next_st.tb_addr = ((instr_i.base_reg == `ITB_REG_PC) ? next_st.tb_next
                                                                 : base_val_i) + offs;
            next_st.tb_half = (instr_i.kind == ITB_K_TBH);
            next_st.tb_req  = 1'b1;
            next_st.tb_busy = 1'b1;
            if (instr_i.base_reg == `ITB_REG_SP || instr_i.index_reg == `ITB_REG_SP ||
                instr_i.index_reg == `ITB_REG_PC) begin
              next_st.fault   = 1'b1;
              next_st.tb_req  = 1'b0;
              next_st.tb_busy = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign blk_state_o = st.blk;
  assign in_block_o  = in_blk;
  assign exec_o      = st.exec;
  assign fault_o     = st.fault;
  assign tbl_req_o   = st.tb_req;
  assign tbl_addr_o  = st.tb_addr;
  assign tbl_half_o  = st.tb_half;
  assign branch_o    = st.branch;
  assign target_o    = st.target;

  // ============================================================
  // Checks
  chk_prefix_loads: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (ready_o && instr_i.valid && !in_blk && instr_i.kind == ITB_K_PREFIX && !instr_i.has_cond
     && !exc_entry_i && !exc_return_i && instr_i.mask_field != 4'h0)
    |=> (st.blk.base_cond == $past(instr_i.cond_field)))
    else $error("prefix did not load base condition");

  chk_block_ends: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (ready_o && instr_i.valid && in_blk && last_slot && !exc_entry_i && !exc_return_i)
    |=> !in_block_o)
    else $error("block did not end after last slot");

  chk_breakpoint_instr_runs: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (ready_o && instr_i.valid && in_blk && instr_i.is_breakpoint_instr && !exc_entry_i && !exc_return_i)
    |=> exec_o)
    else $error("breakpoint suppressed in block");

  chk_restore_blk: assert property (@(posedge clock_i) disable iff (!nrst_i)
    exc_return_i |=> (blk_state_o == $past(exc_restore_i)))
    else $error("block state not restored");

  chk_entry_keeps: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (exc_entry_i && !exc_return_i) |=> $stable(blk_state_o))
    else $error("block state lost on exception entry");

  chk_tb_target: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (st.tb_busy && tbl_valid_i && !exc_entry_i && !exc_return_i && st.tb_half)
    |=> branch_o && target_o == $past(st.tb_next) + {15'h0, $past(tbl_data_i), 1'b0})
    else $error("halfword table target wrong");

  chk_tb_sp_fault: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (tbl_req_o) |-> !fault_o)
    else $error("table request issued on faulting operands");

  chk_bcond_free: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (ready_o && instr_i.valid && !in_blk && instr_i.is_bcond && !exc_entry_i
     && !exc_return_i && instr_i.kind == ITB_K_OTHER) |=> !fault_o)
    else $error("conditional branch faulted outside block");

  // ============================================================
  // Block sequencing checks
  chk_slot_follows: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (taken && in_blk && !last_slot)
    |=> (blk_state_o.base_cond[0] == $past(st.blk.mask[3])
         && blk_state_o.mask == {$past(st.blk.mask[2:0]), 1'b0}))
    else $error("next slot condition not taken from mask");

  chk_mid_stays: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (taken && in_blk && !last_slot) |=> in_block_o)
    else $error("block closed before its last slot");

  chk_always_else: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (taken && !in_blk && instr_i.kind == ITB_K_PREFIX && !instr_i.has_cond
     && instr_i.cond_field == `ITB_COND_ALWAYS
     && (instr_i.mask_field & (instr_i.mask_field - 4'h1)) != 4'h0)
    |=> fault_o)
    else $error("else slot under always condition accepted");

  // ============================================================
  // Placement checks
  chk_nested_fault: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (taken && in_blk && (instr_i.kind == ITB_K_PREFIX || instr_i.is_cbz || instr_i.is_cps))
    |=> fault_o)
    else $error("forbidden instruction accepted in block");

  chk_pc_write_mid: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (taken && in_blk && instr_i.writes_pc && !last_slot) |=> fault_o)
    else $error("counter write accepted before last slot");

  chk_cond_outside: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (taken && !in_blk && instr_i.has_cond && !instr_i.is_bcond) |=> fault_o)
    else $error("conditional instruction accepted outside block");

  chk_bad_suffix: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (taken && in_blk && instr_i.has_cond && instr_i.instr_cond != st.blk.base_cond
     && instr_i.instr_cond != {st.blk.base_cond[3:1], ~st.blk.base_cond[0]})
    |=> fault_o)
    else $error("foreign condition accepted in block");

  chk_nocond_inside: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (taken && in_blk && !instr_i.has_cond && !instr_i.is_breakpoint_instr) |=> fault_o)
    else $error("unconditional form accepted in block");

  // ============================================================
  // Table branch checks
  chk_req_pulse: assert property (@(posedge clock_i) disable iff (!nrst_i)
    tbl_req_o |=> !tbl_req_o)
    else $error("table request longer than one cycle");

  chk_ready_wait: assert property (@(posedge clock_i) disable iff (!nrst_i)
    tbl_req_o |-> !ready_o)
    else $error("fetch not stalled during table read");

  chk_half_addr: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (taken && !in_blk && instr_i.kind == ITB_K_TBH && !instr_i.has_cond
     && instr_i.base_reg != `ITB_REG_PC && instr_i.base_reg != `ITB_REG_SP
     && instr_i.index_reg != `ITB_REG_SP && instr_i.index_reg != `ITB_REG_PC)
    |=> (tbl_half_o && tbl_addr_o == $past(base_val_i) + {$past(index_val_i[30:0]), 1'b0}))
    else $error("halfword entry address wrong");

  chk_pc_base: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (taken && !in_blk && instr_i.kind == ITB_K_TBB && !instr_i.has_cond
     && instr_i.base_reg == `ITB_REG_PC
     && instr_i.index_reg != `ITB_REG_SP && instr_i.index_reg != `ITB_REG_PC)
    |=> (tbl_addr_o == $past(instr_i.pc) + `ITB_INSTR_BYTES + $past(index_val_i)))
    else $error("counter based table address wrong");

  chk_byte_target: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (st.tb_busy && tbl_valid_i && !exc_entry_i && !exc_return_i && !st.tb_half)
    |=> branch_o && target_o == $past(st.tb_next) + {23'h0, $past(tbl_data_i[7:0]), 1'b0})
    else $error("byte table target wrong");

  chk_branch_pulse: assert property (@(posedge clock_i) disable iff (!nrst_i)
    branch_o |=> !branch_o)
    else $error("branch pulse longer than one cycle");

  chk_tb_refused: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (taken && !in_blk && !instr_i.has_cond
     && (instr_i.kind == ITB_K_TBB || instr_i.kind == ITB_K_TBH)
     && (instr_i.base_reg == `ITB_REG_SP || instr_i.index_reg == `ITB_REG_SP
         || instr_i.index_reg == `ITB_REG_PC))
    |=> (fault_o && !tbl_req_o))
    else $error("illegal table operands not refused");

endmodule // itb_decoder

/* File: tb/itb_table_model.sv */
// Table memory that answers the decoder's entry requests
`timescale 1ns/1ps
module itb_table_model (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        req_i,
  input  wire logic [15:0] entry_i,
  input  wire logic [1:0]  lag_i,
  output logic             valid_o,
  output logic [15:0]      data_o
);
  // ============================================================
  // Responder
  // Data bus toggles while idle so a stale entry never looks valid
  initial begin
    valid_o = 1'h0;
    data_o  = 16'h5A5A;
    forever begin
      @(negedge clock_i);
      if (req_i && nrst_i) begin
        repeat (lag_i) begin
          @(negedge clock_i);
          data_o = ~data_o;
        end
        valid_o = 1'h1;
        data_o  = entry_i;
        @(negedge clock_i);
        valid_o = 1'h0;
        data_o  = ~entry_i;
      end else begin
        data_o = ~data_o;
      end
    end
  end
endmodule // itb_table_model

/* File: tb/itb_decoder_tb_top.sv */
// Self-checking testbench for the conditional-block and table-branch decoder
`timescale 1ns/1ps
`include "itb_map.svh"
module itb_decoder_tb_top import itb_pkg::*;;
  logic        clock, nrst, exc_entry, exc_return, tbl_valid, ready, in_block;
  logic        exec, fault, tbl_req, tbl_half, branch;
  logic [3:0]  flags;
  logic [31:0] base_val, index_val, tbl_addr, target;
  logic [15:0] tbl_data, entry;
  logic [1:0]  lag;
  itb_instr_t  instr;
  itb_blk_t    restore, blk_state, saved;
  int          num_errors = 0;
  int          compares = 0;

  itb_decoder u_dut (.clock_i(clock), .nrst_i(nrst), .instr_i(instr), .flags_i(flags),
    .base_val_i(base_val), .index_val_i(index_val), .exc_entry_i(exc_entry),
    .exc_return_i(exc_return), .exc_restore_i(restore), .tbl_valid_i(tbl_valid),
    .tbl_data_i(tbl_data), .ready_o(ready), .blk_state_o(blk_state), .in_block_o(in_block),
    .exec_o(exec), .fault_o(fault), .tbl_req_o(tbl_req), .tbl_addr_o(tbl_addr),
    .tbl_half_o(tbl_half), .branch_o(branch), .target_o(target));
  itb_table_model u_mem (.clock_i(clock), .nrst_i(nrst), .req_i(tbl_req), .entry_i(entry),
    .lag_i(lag), .valid_o(tbl_valid), .data_o(tbl_data));

  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  // ============================================================
  // Checking and closing
  task automatic chk1(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #(8 * 20000);
    num_errors++;
    conclude();
  end

  // ============================================================
  // Expectations and drivers
  function automatic logic pass(logic [3:0] c, logic [3:0] f);
    logic r;
    case (c[3:1])
      3'h0: r = f[2];
      3'h1: r = f[1];
      3'h2: r = f[3];
      3'h3: r = f[0];
      3'h4: r = f[1] & ~f[2];
      3'h5: r = f[3] == f[0];
      3'h6: r = ~f[2] & (f[3] == f[0]);
      default: return 1'h1;
    endcase
    return r ^ c[0];
  endfunction
  function automatic itb_instr_t mk(itb_kind_t k, logic [3:0] c, logic hc);
    itb_instr_t i;
    i = '0;
    i.valid = 1'h1;
    i.kind = k;
    i.cond_field = c;
    i.has_cond = hc;
    i.instr_cond = c;
    i.pc = $urandom & 32'hFFFF_FFFC;
    return i;
  endfunction
  // Back-to-back: the next call drives at the edge where this one checks
  task automatic send(input itb_instr_t i, input logic [3:0] f, input logic ee,
                      input logic ef, input logic ce);
    instr = i;
    flags = f;
    @(negedge clock);
    if (ce) chk1(exec, ee, "exec");
    chk1(fault, ef, "fault");
  endtask
  task automatic idle();
    instr.valid = 1'h0;
    @(negedge clock);
  endtask
  task automatic clear(input itb_blk_t r);
    exc_return = 1'h1;
    restore = r;
    @(negedge clock);
    exc_return = 1'h0;
  endtask
  task automatic blk(input int n, input logic [3:0] fc, input logic bk, input logic ex);
    logic [3:0] m, sc, f;
    itb_instr_t i;
    m = 4'h0;
    for (int k = 1; k < n; k++) m[4-k] = 1'($urandom);
    m[4-n] = 1'h1;
    i = mk(ITB_K_PREFIX, fc, 1'h0);
    i.mask_field = m;
    send(i, flags, 1'h0, 1'h0, 1'h0);
    chk1(in_block, 1'h1, "block open");
    for (int k = 0; k < n; k++) begin
      sc = {fc[3:1], (k == 0) ? fc[0] : m[4-k]};
      i = mk(ITB_K_OTHER, sc, 1'h1);
      i.is_breakpoint_instr = bk && (k == n - 1);
      f = 4'($urandom);
      send(i, f, pass(sc, f) | i.is_breakpoint_instr, 1'h0, 1'h1);
      chk1(in_block, k < n - 1, "block length");
      if (ex && k == 0 && n > 1) begin
        saved = blk_state;
        instr.valid = 1'h0;
        exc_entry = 1'h1;
        @(negedge clock);
        exc_entry = 1'h0;
        chk32(32'(blk_state), 32'(saved), "state held");
        clear(saved);
        chk1(in_block, 1'h1, "state back");
      end
    end
    idle();
  endtask
  task automatic tbr(input logic h, input logic [3:0] br, input logic [3:0] ir, input logic ef);
    itb_instr_t i;
    logic [31:0] a;
    i = mk(h ? ITB_K_TBH : ITB_K_TBB, `ITB_COND_ALWAYS, 1'h0);
    i.base_reg = br;
    i.index_reg = ir;
    base_val = $urandom;
    index_val = $urandom_range(0, 255);
    entry = 16'($urandom);
    lag = 2'($urandom);
    a = (br == `ITB_REG_PC) ? i.pc + `ITB_INSTR_BYTES : base_val;
    a = a + (h ? index_val << `ITB_HALF_SHIFT : index_val);
    send(i, flags, 1'h0, ef, 1'h0);
    chk1(tbl_req, !ef, "request");
    chk1(ready, ef, "ready");
    idle();
    if (!ef) begin
      chk32(tbl_addr, a, "table address");
      chk1(tbl_half, h, "entry width");
      for (int k = 0; k < 20 && branch !== 1'h1; k++) @(negedge clock);
      chk1(branch, 1'h1, "branch");
      a = i.pc + `ITB_INSTR_BYTES + (32'(h ? entry : {8'h00, entry[7:0]}) << 1);
      chk32(target, a, "target");
    end
  endtask

  // ============================================================
  // Main sequence
  initial begin
    itb_instr_t i;
    logic [3:0] f, b;
    nrst = 1'h0;
    instr = '0;
    flags = 4'h0;
    base_val = 32'h0;
    index_val = 32'h0;
    exc_entry = 1'h0;
    exc_return = 1'h0;
    restore = '0;
    entry = 16'h0;
    lag = 2'h0;
    void'($urandom(65393));
    repeat (5) @(negedge clock);
    nrst = 1'h1;
    chk1(ready, 1'h1, "ready after reset");
    for (int n = 1; n <= 4; n++) blk(n, 4'h0, 1'h1, 1'h1);
    repeat (30) blk($urandom_range(1, 4), 4'($urandom_range(0, 13)), 1'($urandom), 1'($urandom));
    i = mk(ITB_K_PREFIX, `ITB_COND_ALWAYS, 1'h0);
    i.mask_field = 4'h4;
    send(i, flags, 1'h0, 1'h0, 1'h0);
    idle();
    clear('0);
    i.mask_field = 4'hC;
    send(i, flags, 1'h0, 1'h1, 1'h0);
    idle();
    clear('0);
    send(mk(ITB_K_OTHER, 4'h0, 1'h1), flags, 1'h0, 1'h1, 1'h0);
    i = mk(ITB_K_OTHER, 4'h1, 1'h1);
    i.is_bcond = 1'h1;
    f = 4'($urandom);
    send(i, f, pass(4'h1, f), 1'h0, 1'h1);
    for (int j = 0; j < 6; j++) begin
      i = mk(ITB_K_PREFIX, 4'h0, 1'h0);
      i.mask_field = 4'h1;
      send(i, flags, 1'h0, 1'h0, 1'h0);
      i = mk(j == 0 ? ITB_K_PREFIX : ITB_K_OTHER, 4'h0, j != 4);
      i.mask_field = 4'h8;
      i.is_cbz = j == 1;
      i.is_cps = j == 2;
      i.writes_pc = j == 3;
      if (j == 5) i.instr_cond = 4'h4;
      send(i, flags, 1'h0, 1'h1, 1'h0);
      idle();
      clear('0);
    end
    repeat (12) begin
      b = 4'($urandom_range(0, 14));
      tbr(1'($urandom), b == `ITB_REG_SP ? `ITB_REG_PC : b, 4'($urandom_range(0, 12)), 1'h0);
    end
    tbr(1'h1, `ITB_REG_PC, 4'h0, 1'h0);
    tbr(1'h0, `ITB_REG_SP, 4'h1, 1'h1);
    tbr(1'h1, 4'h2, `ITB_REG_SP, 1'h1);
    tbr(1'h0, 4'h2, `ITB_REG_PC, 1'h1);
    conclude();
  end
endmodule // itb_decoder_tb_top
